// ---- rxm_consts.svh ----
`ifndef RXM_CONSTS_SVH
`define RXM_CONSTS_SVH

// host bus register addresses
`define RXM_ADDR_RESET 8'h01
`define RXM_ADDR_GEN_CTRL 8'he0
`define RXM_ADDR_TX_MODE 8'he1
`define RXM_ADDR_RX_MODE 8'he2
`define RXM_ADDR_TX_DATA 8'he3
`define RXM_ADDR_RX_DATA 8'he5
`define RXM_ADDR_STATUS 8'he6
`define RXM_ADDR_TONE_PROG 8'he8

// reset values
`define RXM_REG_RESET 16'h0000
`define RXM_BYTE_RESET 8'h00

// status bit positions
`define RXM_ST_EVEN_PARITY 1
`define RXM_ST_FRAMING 2
`define RXM_ST_OVERFLOW 3
`define RXM_ST_RX_READY 4
`define RXM_ST_ONES 7
`define RXM_ST_ZEROS 8
`define RXM_ST_ALT 9
`define RXM_ST_ENERGY 10

// general control: set to switch the receive equaliser off
`define RXM_GC_EQU_OFF 10

// receive mode fields
`define RXM_RM_MODE_HI 15
`define RXM_RM_MODE_LO 12
`define RXM_RM_SYNC 5
`define RXM_RM_DBITS_HI 4
`define RXM_RM_DBITS_LO 3
`define RXM_RM_PAR_EN 2
`define RXM_RM_STOP2 0

// receive mode codes; any other code is a non-modem mode
`define RXM_MODE_1200 4'h1
`define RXM_MODE_300 4'h2
`define RXM_MODE_150 4'h3
`define RXM_MODE_75 4'h4

// pattern detector run length and hold time in bits
`define RXM_PAT_RUN 6'h20
`define RXM_PAT_HOLD 4'hc

// clock rate and bit rates in Hz
`define RXM_CLK_HZ 250000000
`define RXM_RATE_1200 1200
`define RXM_RATE_300 300
`define RXM_RATE_150 150
`define RXM_RATE_75 75

`endif

// ---- rxm_pkg.sv ----
package rxm_pkg;

	// receive usart states
	typedef enum logic [2:0] {
		RX_HUNT,
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_PARITY,
		RX_STOP
	} rxm_rx_e;

	// serial host port state
	typedef struct packed {
		logic sclk_s1;
		logic sclk_s2;
		logic sclk_d;
		logic csn_s1;
		logic csn_s2;
		logic cmd_s1;
		logic cmd_s2;
		logic [2:0] bit_cnt;
		logic [7:0] in_sh;
		logic have_addr;
		logic [7:0] addr;
		logic byte_idx;
		logic [15:0] out_sh;
		logic [3:0] out_left;
		logic reply;
		logic addr_stb;
		logic data_stb;
		logic [7:0] data_byte;
		logic rd_load;
	} rxm_bus_s;

	// pattern detector state
	typedef struct packed {
		logic last;
		logic [2:0][5:0] run;
		logic [2:0][3:0] hold;
		logic [2:0] det;
	} rxm_pat_s;

	// top level state
	typedef struct packed {
		logic [15:0] general_control;
		logic [15:0] transmit_mode;
		logic [15:0] receive_mode;
		logic [7:0] transmit_data;
		logic [15:0] tone_programming;
		logic [7:0] wr_hi;
		logic [7:0] receive_data;
		logic st_ready;
		logic st_over;
		logic st_frame;
		logic st_even;
		logic bit_s1;
		logic bit_s2;
		logic bit_d;
		logic nrg_s1;
		logic nrg_s2;
		logic [21:0] tmr;
		rxm_rx_e rx_state;
		logic [7:0] rx_buf;
		logic [3:0] rx_n;
		logic par_bit;
		logic [6:0] prev_mode;
	} rxm_top_s;

endpackage

// ---- rxm_bus_port.sv ----
`timescale 1ns/10ps
`include "rxm_consts.svh"

module rxm_bus_port
	import rxm_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// serial pins
	input wire logic serial_clock,
	input wire logic chip_select_n,
	input wire logic command_data,
	output logic reply_data,
	output logic reply_data_oe,
	// register side
	output logic [7:0] addr,
	output logic addr_stb,
	output logic data_stb,
	output logic [7:0] data_byte,
	output logic byte_idx,
	output logic rd_load,
	input wire logic [15:0] rd_word,
	input wire logic rd_is16,
	input wire logic rd_valid
);
	rxm_bus_s st;
	rxm_bus_s next_st;
	logic rise;
	logic fall;

	// pins pass two flops; edges are found on the second stage only
	always_comb
	begin
		next_st = st;
		next_st.sclk_s1 = serial_clock;
		next_st.sclk_s2 = st.sclk_s1;
		next_st.sclk_d = st.sclk_s2;
		next_st.csn_s1 = chip_select_n;
		next_st.csn_s2 = st.csn_s1;
		next_st.cmd_s1 = command_data;
		next_st.cmd_s2 = st.cmd_s1;
		next_st.addr_stb = 1'b0;
		next_st.data_stb = 1'b0;
		next_st.rd_load = 1'b0;
		rise = st.sclk_s2 & ~st.sclk_d;
		fall = ~st.sclk_s2 & st.sclk_d;
		if (st.csn_s2)
		begin
			// idle between transfers: forget any partial byte
			next_st.bit_cnt = 3'h0;
			next_st.have_addr = 1'b0;
			next_st.byte_idx = 1'b0;
			next_st.out_left = 4'h0;
		end
		else
		begin
			if (rise)
			begin
				// command bits arrive msb first on rising edges
				next_st.in_sh = {st.in_sh[6:0], st.cmd_s2};
				next_st.bit_cnt = st.bit_cnt + 3'h1;
				if (st.bit_cnt == 3'h7)
				begin
					if (!st.have_addr)
					begin
						next_st.have_addr = 1'b1;
						next_st.addr = {st.in_sh[6:0], st.cmd_s2};
						next_st.addr_stb = 1'b1;
					end
					else
					begin
						next_st.data_stb = 1'b1;
						next_st.data_byte = {st.in_sh[6:0], st.cmd_s2};
						next_st.byte_idx = ~st.byte_idx;
					end
				end
			end
			// reply changes on falling edges so it is steady while high
			if (fall && st.have_addr && rd_valid)
			begin
				if (st.out_left == 4'h0)
				begin
					// reload: first byte of a word is the high one
					next_st.rd_load = 1'b1;
					next_st.reply = rd_is16 ? rd_word[15] : rd_word[7];
					next_st.out_sh = rd_is16 ? {rd_word[14:0], 1'b0}
						: {rd_word[6:0], 9'h000};
					next_st.out_left = rd_is16 ? 4'hf : 4'h7;
				end
				else
				begin
					next_st.reply = st.out_sh[15];
					next_st.out_sh = {st.out_sh[14:0], 1'b0};
					next_st.out_left = st.out_left - 4'h1;
				end
			end
		end
	end

	// state register
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign reply_data = st.reply;
	assign reply_data_oe = ~st.csn_s2 & st.have_addr & rd_valid;
	assign addr = st.addr;
	assign addr_stb = st.addr_stb;
	assign data_stb = st.data_stb;
	assign data_byte = st.data_byte;
	// the toggle lands with the strobe, so invert to name the byte just taken
	assign byte_idx = ~st.byte_idx;
	assign rd_load = st.rd_load;
endmodule

// ---- rxm_pattern.sv ----
`timescale 1ns/10ps
`include "rxm_consts.svh"

module rxm_pattern
	import rxm_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// bit stream
	input wire logic bit_stb,
	input wire logic bit_val,
	input wire logic clear,
	input wire logic [5:0] zero_limit,
	// detect outputs: 0 ones, 1 zeros, 2 alternating
	output logic [2:0] det
);
	rxm_pat_s st;
	rxm_pat_s next_st;
	logic [2:0] cont;
	logic [2:0][5:0] limit;

	// one counter per pattern; runs saturate so long runs stay detected
	always_comb
	begin
		next_st = st;
		cont = {bit_val != st.last, ~bit_val, bit_val};
		limit = {`RXM_PAT_RUN, zero_limit, `RXM_PAT_RUN};
		if (clear)
			next_st = '0;
		else if (bit_stb)
		begin
			next_st.last = bit_val;
			for (int i = 0; i < 3; i++)
			begin
				if (cont[i])
					next_st.run[i] = (st.run[i] == 6'h3f) ? st.run[i]
						: st.run[i] + 6'h1;
				else
					next_st.run[i] = (i == 2) ? 6'h01 : 6'h00;
				if (cont[i] && next_st.run[i] >= limit[i])
				begin
					next_st.det[i] = 1'b1;
					next_st.hold[i] = `RXM_PAT_HOLD;
				end
				else if (st.det[i])
				begin
					// count down bit times after the pattern broke
					next_st.hold[i] = st.hold[i] - 4'h1;
					if (st.hold[i] <= 4'h1)
						next_st.det[i] = 1'b0;
				end
			end
		end
	end

	// state register
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign det = st.det;
endmodule

// ---- rxm_top.sv ----
`timescale 1ns/10ps
`include "rxm_consts.svh"

module rxm_top
	import rxm_pkg::*;
#(
	parameter int BIT_CYC_1200 = `RXM_CLK_HZ / `RXM_RATE_1200,
	parameter int BIT_CYC_300 = `RXM_CLK_HZ / `RXM_RATE_300,
	parameter int BIT_CYC_150 = `RXM_CLK_HZ / `RXM_RATE_150,
	parameter int BIT_CYC_75 = `RXM_CLK_HZ / `RXM_RATE_75
)
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// serial host pins
	input wire logic serial_clock,
	input wire logic chip_select_n,
	input wire logic command_data,
	output logic reply_data,
	output logic reply_data_oe,
	// from the analog receive path
	input wire logic rx_tone_mark,
	input wire logic energy_over_threshold,
	// control outputs to the rest of the device
	output logic equaliser_on,
	output logic [15:0] general_control,
	output logic [15:0] transmit_mode,
	output logic [15:0] receive_mode,
	output logic [7:0] transmit_data,
	output logic [15:0] tone_programming
);
	rxm_top_s st;
	rxm_top_s next_st;
	logic [7:0] bus_addr;
	logic addr_stb;
	logic data_stb;
	logic [7:0] data_byte;
	logic byte_idx;
	logic rd_load;
	logic [15:0] rd_word;
	logic rd_is16;
	logic rd_valid;
	logic [2:0] det;
	logic [3:0] mode;
	logic modem;
	logic sync_mode;
	logic [1:0] dbit_sel;
	logic [3:0] dbits;
	logic par_en;
	logic [21:0] period;
	logic edge_seen;
	logic bit_stb;
	logic line;
	logic xfer;
	logic [7:0] xfer_data;
	logic rd_clr;
	logic reset_cmd;
	logic pat_clear;
	logic [4:0] char_bits;
	logic [5:0] zero_limit;
	logic [15:0] status;
	logic [7:0] aligned;

	// serial host port
	rxm_bus_port u_bus (
		.clk(clk),
		.reset_n(reset_n),
		.serial_clock(serial_clock),
		.chip_select_n(chip_select_n),
		.command_data(command_data),
		.reply_data(reply_data),
		.reply_data_oe(reply_data_oe),
		.addr(bus_addr),
		.addr_stb(addr_stb),
		.data_stb(data_stb),
		.data_byte(data_byte),
		.byte_idx(byte_idx),
		.rd_load(rd_load),
		.rd_word(rd_word),
		.rd_is16(rd_is16),
		.rd_valid(rd_valid)
	);

	// the three pattern detectors share one bit strobe
	rxm_pattern u_pat (
		.clk(clk),
		.reset_n(reset_n),
		.bit_stb(bit_stb),
		.bit_val(line),
		.clear(pat_clear),
		.zero_limit(zero_limit),
		.det(det)
	);

	// receive mode decode
	always_comb
	begin
		mode = st.receive_mode[`RXM_RM_MODE_HI:`RXM_RM_MODE_LO];
		sync_mode = st.receive_mode[`RXM_RM_SYNC];
		dbit_sel = st.receive_mode[`RXM_RM_DBITS_HI:`RXM_RM_DBITS_LO];
		dbits = 4'h5 + {2'b00, dbit_sel};
		par_en = st.receive_mode[`RXM_RM_PAR_EN];
		modem = 1'b1;
		case (mode)
			`RXM_MODE_1200: period = 22'(BIT_CYC_1200);
			`RXM_MODE_300: period = 22'(BIT_CYC_300);
			`RXM_MODE_150: period = 22'(BIT_CYC_150);
			`RXM_MODE_75: period = 22'(BIT_CYC_75);
			default:
			begin
				period = 22'(BIT_CYC_1200);
				modem = 1'b0;
			end
		endcase
	end

	// start, data, parity and stop bits make up one character
	always_comb
	begin
		char_bits = 5'h01 + {1'b0, dbits} + {4'h0, par_en}
			+ {4'h0, st.receive_mode[`RXM_RM_STOP2]} + 5'h01;
		if (sync_mode)
			zero_limit = `RXM_PAT_RUN;
		else
			zero_limit = {char_bits, 1'b0} + 6'h04;
	end

	// the demodulated tone level is the received data bit
	assign line = st.bit_s2;
	assign edge_seen = st.bit_s2 ^ st.bit_d;
	assign bit_stb = modem && !edge_seen && st.tmr == 22'h00_0000;

	// pattern detectors restart on a new rate or mode
	assign pat_clear = !modem
		|| st.receive_mode[15:9] != st.prev_mode;

	// address decode for reads
	always_comb
	begin
		rd_valid = 1'b1;
		rd_is16 = 1'b0;
		rd_word = `RXM_REG_RESET;
		case (bus_addr)
			`RXM_ADDR_RX_DATA: rd_word = {8'h00, st.receive_data};
			`RXM_ADDR_STATUS:
			begin
				rd_word = status;
				rd_is16 = 1'b1;
			end
			default: rd_valid = 1'b0;
		endcase
	end

	// status word
	always_comb
	begin
		status = `RXM_REG_RESET;
		status[`RXM_ST_EVEN_PARITY] = st.st_even;
		status[`RXM_ST_FRAMING] = st.st_frame;
		status[`RXM_ST_OVERFLOW] = st.st_over;
		status[`RXM_ST_RX_READY] = st.st_ready;
		status[`RXM_ST_ONES] = det[0];
		status[`RXM_ST_ZEROS] = det[1];
		status[`RXM_ST_ALT] = det[2];
		status[`RXM_ST_ENERGY] = st.nrg_s2 & modem;
	end

	// a read of the data register begins with a reload
	assign rd_clr = rd_load && bus_addr == `RXM_ADDR_RX_DATA;
	assign reset_cmd = addr_stb && bus_addr == `RXM_ADDR_RESET;

	// async data bits were shifted in lsb first from the top
	always_comb
	begin
		case (dbit_sel)
			2'h0: aligned = {3'h0, st.rx_buf[7:3]};
			2'h1: aligned = {2'h0, st.rx_buf[7:2]};
			2'h2: aligned = {1'h0, st.rx_buf[7:1]};
			default: aligned = st.rx_buf;
		endcase
	end

	// main next-state logic
	always_comb
	begin
		next_st = st;
		xfer = 1'b0;
		xfer_data = st.rx_buf;
		next_st.bit_s1 = rx_tone_mark;
		next_st.bit_s2 = st.bit_s1;
		next_st.bit_d = st.bit_s2;
		next_st.nrg_s1 = energy_over_threshold;
		next_st.nrg_s2 = st.nrg_s1;
		next_st.prev_mode = st.receive_mode[15:9];

		// bit timer realigns to mid-bit on every line transition
		if (edge_seen)
			next_st.tmr = {1'b0, period[21:1]};
		else if (st.tmr == 22'h00_0000)
			next_st.tmr = period - 22'h00_0001;
		else
			next_st.tmr = st.tmr - 22'h00_0001;

		// receive usart
		if (!modem)
		begin
			next_st.rx_state = RX_HUNT;
			next_st.rx_n = 4'h0;
		end
		else if (sync_mode)
		begin
			if (bit_stb)
			begin
				next_st.rx_buf = {line, st.rx_buf[7:1]};
				next_st.rx_n = st.rx_n + 4'h1;
				if (st.rx_n == 4'h7)
				begin
					next_st.rx_n = 4'h0;
					xfer = 1'b1;
					xfer_data = {line, st.rx_buf[7:1]};
				end
			end
		end
		else
		begin
			case (st.rx_state)
				RX_HUNT:
				begin
					// wait for a one before a start edge counts
					if (line)
						next_st.rx_state = RX_IDLE;
				end
				RX_IDLE:
				begin
					if (edge_seen && !line)
						next_st.rx_state = RX_START;
				end
				RX_START:
				begin
					// a start that is gone at mid-bit was a glitch
					if (bit_stb)
					begin
						next_st.rx_n = 4'h0;
						next_st.rx_state = line ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA:
				begin
					if (bit_stb)
					begin
						next_st.rx_buf = {line, st.rx_buf[7:1]};
						next_st.rx_n = st.rx_n + 4'h1;
						if (st.rx_n + 4'h1 == dbits)
							next_st.rx_state = par_en ? RX_PARITY : RX_STOP;
					end
				end
				RX_PARITY:
				begin
					if (bit_stb)
					begin
						next_st.par_bit = line;
						next_st.rx_state = RX_STOP;
					end
				end
				RX_STOP:
				begin
					if (bit_stb)
					begin
						xfer = 1'b1;
						xfer_data = aligned;
						next_st.st_frame = !line;
						next_st.st_even = !(^aligned
							^ (par_en & st.par_bit));
						next_st.rx_state = line ? RX_IDLE : RX_HUNT;
					end
				end
				default: next_st.rx_state = RX_HUNT;
			endcase
		end

		// data register and flags; a new character wins over a read
		if (xfer)
			next_st.receive_data = xfer_data;
		next_st.st_ready = (st.st_ready & !rd_clr) | xfer;
		next_st.st_over = (st.st_over & !rd_clr)
			| (xfer & st.st_ready & !rd_clr);

		// register writes: 16-bit words need the high byte first
		if (data_stb)
		begin
			if (!byte_idx)
				next_st.wr_hi = data_byte;
			case (bus_addr)
				`RXM_ADDR_GEN_CTRL:
					if (byte_idx)
						next_st.general_control = {st.wr_hi, data_byte};
				`RXM_ADDR_TX_MODE:
					if (byte_idx)
						next_st.transmit_mode = {st.wr_hi, data_byte};
				`RXM_ADDR_RX_MODE:
					if (byte_idx)
						next_st.receive_mode = {st.wr_hi, data_byte};
				`RXM_ADDR_TONE_PROG:
					if (byte_idx)
						next_st.tone_programming = {st.wr_hi, data_byte};
				`RXM_ADDR_TX_DATA: next_st.transmit_data = data_byte;
				// test addresses and read-only registers ignore writes
				default: next_st.wr_hi = next_st.wr_hi;
			endcase
		end

		// reset command clears control, modes and status flags
		if (reset_cmd)
		begin
			next_st.general_control = `RXM_REG_RESET;
			next_st.transmit_mode = `RXM_REG_RESET;
			next_st.receive_mode = `RXM_REG_RESET;
			next_st.st_ready = 1'b0;
			next_st.st_over = 1'b0;
			next_st.st_frame = 1'b0;
			next_st.st_even = 1'b0;
			next_st.rx_state = RX_HUNT;
		end
	end

	// state register
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			st <= '0;
		else
			st <= next_st;
	end

	// equaliser only in the 1200 bit/s receive mode
	assign equaliser_on = mode == `RXM_MODE_1200
		&& !st.general_control[`RXM_GC_EQU_OFF];
	assign general_control = st.general_control;
	assign transmit_mode = st.transmit_mode;
	assign receive_mode = st.receive_mode;
	assign transmit_data = st.transmit_data;
	assign tone_programming = st.tone_programming;
endmodule

// ---- rxm_host_model.sv ----
`timescale 1ns/10ps

module rxm_host_model
(
	// core clock paces the serial bus
	input wire logic clk,
	// serial bus pins
	output logic serial_clock,
	output logic chip_select_n,
	output logic command_data,
	input wire logic reply_data,
	input wire logic reply_data_oe
);
	// bus idles deselected with the serial clock low
	initial
	begin
		serial_clock = 1'b0;
		chip_select_n = 1'b1;
		command_data = 1'b0;
	end

	// one transaction: address byte then n data bits, 6 clk per half period
	task automatic xfer(input logic [7:0] a, input int n,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [31:0] sh;
		sh = {a, 16'(wd << (16 - n)), 8'h00};
		rd = 16'h0000;
		@(posedge clk) chip_select_n <= 1'b0;
		for (int i = 0; i < 8 + n; i++)
		begin
			@(posedge clk) serial_clock <= 1'b0;
			command_data <= sh[31 - i];
			repeat (6) @(posedge clk);
			serial_clock <= 1'b1;
			// a released reply line reads as the inverse of its last level
			rd = {rd[14:0], reply_data_oe ? reply_data : !reply_data};
			repeat (5) @(posedge clk);
		end
		@(posedge clk) serial_clock <= 1'b0;
		command_data <= ~command_data;
		repeat (6) @(posedge clk);
		chip_select_n <= 1'b1;
		// gap between transfers; callers never pass test addresses
		repeat (12) @(posedge clk);
	endtask
endmodule

// ---- rxm_top_checker.sv ----
`timescale 1ns/10ps

module rxm_top_checker
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// serial host pins
	input wire logic serial_clock,
	input wire logic chip_select_n,
	input wire logic command_data,
	input wire logic reply_data,
	input wire logic reply_data_oe,
	// receive path
	input wire logic rx_tone_mark,
	input wire logic energy_over_threshold,
	// register copies
	input wire logic equaliser_on,
	input wire logic [15:0] general_control,
	input wire logic [15:0] transmit_mode,
	input wire logic [15:0] receive_mode,
	input wire logic [7:0] transmit_data,
	input wire logic [15:0] tone_programming
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	logic [7:0] sel_age;
	logic [7:0] hi_age;
	logic [7:0] rise_age;
	logic sclk_d;
	logic csn_d;

	// ages saturate so a long idle span never wraps into a window;
	// select age runs from the falling edge, so the synchroniser lag
	// after deselect still counts as late in the transfer
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sel_age <= 8'hff;
			hi_age <= 8'hff;
			rise_age <= 8'hff;
			sclk_d <= 1'b0;
			csn_d <= 1'b1;
		end
		else
		begin
			sclk_d <= serial_clock;
			csn_d <= chip_select_n;
			sel_age <= (!chip_select_n && csn_d) ? 8'h00 :
				sel_age + 8'(sel_age != 8'hff);
			hi_age <= !chip_select_n ? 8'h00 : hi_age + 8'(hi_age != 8'hff);
			rise_age <= (serial_clock && !sclk_d) ? 8'h00 :
				rise_age + 8'(rise_age != 8'hff);
		end
	end

	sequence s_deselected;
		chip_select_n [*6];
	endsequence
	sequence s_reply_rise;
		$rose(serial_clock) ##0 reply_data_oe;
	endsequence

	a_equ_gate: assert property (equaliser_on ==
		(receive_mode[15:12] == 4'h1 && !general_control[10]))
		else $error("equaliser output disagrees with mode and control");
	a_oe_deselect: assert property (s_deselected |-> !reply_data_oe)
		else $error("reply driven while deselected");
	a_oe_after_addr: assert property (reply_data_oe |->
		sel_age > 8'h3c)
		else $error("reply driven before address byte");
	a_addr_quiet: assert property ($fell(chip_select_n) |=>
		!reply_data_oe [*8])
		else $error("reply driven at select start");
	a_reply_holds: assert property (s_reply_rise |=>
		$stable(reply_data) [*3])
		else $error("reply moved while serial clock high");
	a_ctrl_on_edge: assert property ($changed(general_control) ||
		$changed(transmit_mode) |-> rise_age < 8'h08)
		else $error("control written away from a serial rising edge");
	a_mode_in_xfer: assert property ($changed(receive_mode) |->
		hi_age < 8'h06)
		else $error("receive mode written outside a transfer");
	a_data_in_xfer: assert property ($changed(transmit_data) ||
		$changed(tone_programming) |-> hi_age < 8'h06 && rise_age < 8'h08)
		else $error("data register written outside a transfer");
endmodule

bind rxm_top rxm_top_checker chk (.clk(clk), .reset_n(reset_n),
	.serial_clock(serial_clock), .chip_select_n(chip_select_n),
	.command_data(command_data), .reply_data(reply_data),
	.reply_data_oe(reply_data_oe), .rx_tone_mark(rx_tone_mark),
	.energy_over_threshold(energy_over_threshold),
	.equaliser_on(equaliser_on), .general_control(general_control),
	.transmit_mode(transmit_mode), .receive_mode(receive_mode),
	.transmit_data(transmit_data), .tone_programming(tone_programming));

// ---- tb_top.sv ----
`timescale 1ns/10ps

module tb_top;
	logic clk;
	logic reset_n;
	logic serial_clock;
	logic chip_select_n;
	logic command_data;
	logic reply_data;
	logic reply_data_oe;
	logic rx_tone_mark;
	logic energy_over_threshold;
	logic equaliser_on;
	logic [15:0] general_control;
	logic [15:0] transmit_mode;
	logic [15:0] receive_mode;
	logic [7:0] transmit_data;
	logic [15:0] tone_programming;
	int errors;
	int samples_checked;
	localparam int BIT = 64;

	// 250 MHz core clock
	initial clk = 1'b0;
	always #2 clk = ~clk;

	// short bit periods keep the run brief
	rxm_top #(.BIT_CYC_1200(BIT), .BIT_CYC_300(128), .BIT_CYC_150(200),
		.BIT_CYC_75(256)) dut (.clk(clk), .reset_n(reset_n),
		.serial_clock(serial_clock), .chip_select_n(chip_select_n),
		.command_data(command_data), .reply_data(reply_data),
		.reply_data_oe(reply_data_oe), .rx_tone_mark(rx_tone_mark),
		.energy_over_threshold(energy_over_threshold),
		.equaliser_on(equaliser_on), .general_control(general_control),
		.transmit_mode(transmit_mode), .receive_mode(receive_mode),
		.transmit_data(transmit_data), .tone_programming(tone_programming));
	rxm_host_model host (.clk(clk), .serial_clock(serial_clock),
		.chip_select_n(chip_select_n), .command_data(command_data),
		.reply_data(reply_data), .reply_data_oe(reply_data_oe));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("errors %0d, samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// register access helpers
	task automatic wr(input logic [7:0] a, input int n, input logic [15:0] d);
		logic [15:0] v;
		host.xfer(a, n, d, v);
	endtask
	task automatic st(input logic [15:0] mask, input logic [15:0] exp);
		logic [15:0] v;
		host.xfer(8'he6, 16, 16'h0000, v);
		check(v & mask, exp);
	endtask
	task automatic rdd(input logic [7:0] exp);
		logic [15:0] v;
		host.xfer(8'he5, 8, 16'h0000, v);
		// only the byte after the address carries data
		check({8'h00, v[7:0]}, {8'h00, exp});
	endtask

	// line bits go out lsb first, one bit period each
	task automatic bits(input logic [15:0] v, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk) rx_tone_mark <= v[i];
			repeat (BIT - 1) @(posedge clk);
		end
	endtask
	task automatic chr(input logic [7:0] d, input logic stop);
		bits({6'h00, stop, d, 1'b0}, 10);
	endtask

	// a hang counts as a mismatch
	initial
	begin
		repeat (60000) @(posedge clk);
		errors++;
		conclude();
	end

	// main sequence, 8 data bits no parity one stop (M = 10)
	initial
	begin
		errors = 0;
		samples_checked = 0;
		reset_n = 1'b0;
		rx_tone_mark = 1'b1;
		energy_over_threshold = 1'b0;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		wr(8'he6, 16, 16'hffff);
		st(16'hffff, 16'h0000);
		wr(8'he0, 16, 16'h0400);
		wr(8'he1, 16, 16'h1234);
		wr(8'he3, 8, 16'h005a);
		wr(8'he8, 16, 16'hbeef);
		wr(8'he2, 16, 16'h1018);
		check(general_control, 16'h0400);
		check(transmit_mode, 16'h1234);
		check({8'h00, transmit_data}, 16'h005a);
		check(tone_programming, 16'hbeef);
		check(receive_mode, 16'h1018);
		check({15'h0000, equaliser_on}, 16'h0000);
		wr(8'he0, 16, 16'h0000);
		check({15'h0000, equaliser_on}, 16'h0001);
		energy_over_threshold <= 1'b1;
		repeat (3) bits(16'hffff, 16);
		st(16'hffff, 16'h0480);
		chr(8'ha5, 1'b1);
		st(16'h001e, 16'h0012);
		rdd(8'ha5);
		// a read leaves the parity flag of the last character alone
		st(16'h001e, 16'h0002);
		chr(8'h03, 1'b1);
		chr(8'h80, 1'b1);
		st(16'h001e, 16'h0018);
		rdd(8'h80);
		st(16'h001e, 16'h0000);
		chr(8'h81, 1'b0);
		bits(16'h0003, 2);
		st(16'h001e, 16'h0016);
		rdd(8'h81);
		chr(8'h07, 1'b1);
		st(16'h001e, 16'h0010);
		rdd(8'h07);
		bits(16'h0000, 16);
		bits(16'h0000, 7);
		bits(16'h0001, 1);
		st(16'h0104, 16'h0004);
		bits(16'h0000, 16);
		bits(16'h0000, 8);
		bits(16'h0001, 1);
		st(16'h0104, 16'h0104);
		bits(16'hffff, 14);
		st(16'h0100, 16'h0000);
		bits(16'haaaa, 16);
		bits(16'haaaa, 16);
		st(16'h0200, 16'h0200);
		wr(8'he2, 16, 16'h2018);
		st(16'h0380, 16'h0000);
		// 7 data bits with parity; the parity bit counts toward even
		wr(8'he2, 16, 16'h1014);
		bits({6'h00, 1'b1, 1'b1, 7'h45, 1'b0}, 10);
		st(16'h0006, 16'h0002);
		rdd(8'h45);
		// synchronous: after ones, 32 zeros are sent and the line stays low through the status read
		wr(8'he2, 16, 16'h1020);
		bits(16'hffff, 16);
		bits(16'h0000, 16);
		bits(16'h0000, 16);
		st(16'h0100, 16'h0100);
		rdd(8'h00);
		wr(8'h01, 0, 16'h0000);
		check(receive_mode | general_control | transmit_mode, 16'h0000);
		st(16'hffff, 16'h0000);
		conclude();
	end
endmodule
